// [shared/tsilc_pkg.sv]
// constants and types shared by the latency control block
package tsilc_pkg;
  // frame geometry at the full 8.192 Mbit/s rate
  localparam int          SLOT_W          = 7;
  localparam int          DELTA_W         = 8;
  localparam int          LAT_W           = 9;
  localparam int          CALC_W          = 10;
  localparam int          FRAME_SHIFT     = 7;
  localparam int          STREAM_W_DEF    = 5;

  // latency bases and special-case figures, in full-rate slots
  localparam logic [LAT_W-1:0] LAT_ONE_FRAME   = 9'h080;
  localparam logic [LAT_W-1:0] LAT_TWO_FRAMES  = 9'h100;
  localparam logic [LAT_W-1:0] LAT_PIPE_LONG   = 9'h101;
  localparam logic [LAT_W-1:0] LAT_PIPE_LONGER = 9'h102;
  localparam logic [LAT_W-1:0] LAT_PIPE_SHORT  = 9'h002;

  // slot deltas where the pipeline meets the double buffering
  localparam logic [DELTA_W-1:0] DELTA_P1   = 8'h01;
  localparam logic [DELTA_W-1:0] DELTA_P2   = 8'h02;
  localparam logic [DELTA_W-1:0] DELTA_M126 = 8'h82;
  localparam logic [DELTA_W-1:0] DELTA_M127 = 8'h81;

  // stream rate of a slot index
  typedef enum logic [1:0] {
    TSILC_RATE_8M,
    TSILC_RATE_4M,
    TSILC_RATE_2M
  } tsilc_rate_e;
endpackage

// [src/tsilc_slot_scale.sv]
// registered scaling of a slot index to the full-rate slot grid
`timescale 1ns/100ps
module tsilc_slot_scale
  import tsilc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire tsilc_rate_e       rate,
  input  wire logic [SLOT_W-1:0] slot,
  output logic      [SLOT_W-1:0] slot_full
);
  logic [SLOT_W-1:0] scaled;

  // upper index bits beyond the stream's own slot count are dropped
  assign scaled = (rate == TSILC_RATE_4M) ? {slot[SLOT_W-2:0], 1'b0} :
                  (rate == TSILC_RATE_2M) ? {slot[SLOT_W-3:0], 2'b00} :
                  slot;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slot_full <= '0;
    end else begin
      slot_full <= scaled;
    end
  end
endmodule

// [src/tsilc_latency.sv]
// connection latency and buffer-select decision for the slot interchanger
`timescale 1ns/100ps
// Function
// - forward with buffer select one gives 128 plus the slot delta.
// - reverse with buffer select zero gives 256 plus the slot delta.
// - forward with buffer select zero gives the slot delta itself.
// - reverse with buffer select one gives 128 plus the slot delta.
// - deltas +1 (select zero) and -127 (select one) give 257 always.
// - deltas +2 (zero) and -126 (one) give 258 if streams go down, else 2.
// - override with global select zero behaves as a per-connection zero.
// - override with global select one gives 128 plus delta for all but the -127 and -126 deltas.
// - under override the global select picks the special cases too.
// - slower stream slot indices are scaled by two or four first.
// - constant delay lands 129 to 256 slots after the source slot.
// - each connection carries its own buffer-select bit.
// - the override bit replaces every per-connection select bit.
// - forward means destination slot above source, deltas are to - from.
module tsilc_latency
  import tsilc_pkg::*;
#(
  parameter int STREAM_W = STREAM_W_DEF
) (
  input  wire logic                mclk,
  input  wire logic                arst_n,
  input  wire logic                req_valid,
  input  wire logic [SLOT_W-1:0]   from_slot,
  input  wire logic [SLOT_W-1:0]   to_slot,
  input  wire tsilc_rate_e         from_rate,
  input  wire tsilc_rate_e         to_rate,
  input  wire logic [STREAM_W-1:0] from_stream,
  input  wire logic [STREAM_W-1:0] to_stream,
  input  wire logic                buffer_select_bit,
  input  wire logic                override_en,
  input  wire logic                global_select,
  output logic                     res_valid,
  output logic      [LAT_W-1:0]    res_latency,
  output logic      [1:0]          res_frame_offset,
  output logic                     res_buffer_select,
  output logic                     res_min_delay,
  output logic                     res_exception,
  output logic                     res_self_loop
);
  logic [SLOT_W-1:0]   src_full;
  logic [SLOT_W-1:0]   dst_full;
  logic                s_valid;
  logic [STREAM_W-1:0] s_from_stream;
  logic [STREAM_W-1:0] s_to_stream;
  logic                s_bs;
  logic                s_ovr;
  logic                s_gsel;

  tsilc_slot_scale u_src_scale (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .rate      (from_rate),
    .slot      (from_slot),
    .slot_full (src_full)
  );

  tsilc_slot_scale u_dst_scale (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .rate      (to_rate),
    .slot      (to_slot),
    .slot_full (dst_full)
  );

  // the per-connection bit travels with its request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_valid       <= 1'b0;
      s_from_stream <= '0;
      s_to_stream   <= '0;
      s_bs          <= 1'b0;
      s_ovr         <= 1'b0;
      s_gsel        <= 1'b0;
    end else begin
      s_valid       <= req_valid;
      s_from_stream <= from_stream;
      s_to_stream   <= to_stream;
      s_bs          <= buffer_select_bit;
      s_ovr         <= override_en;
      s_gsel        <= global_select;
    end
  end

  logic [DELTA_W-1:0] slot_delta;
  logic               forward;
  logic               stream_neg;
  logic               stream_same;
  logic               eff_bs;
  logic [CALC_W-1:0]  d_ext;
  logic               exc_long;
  logic               exc_short;
  logic               is_exc;
  logic [CALC_W-1:0]  lat_base;
  logic [CALC_W-1:0]  lat_lin;
  logic [LAT_W-1:0]   next_latency;
  logic [CALC_W-1:0]  dst_abs;

  assign slot_delta  = DELTA_W'({1'b0, dst_full} - {1'b0, src_full});
  assign forward     = (dst_full > src_full);
  assign stream_neg  = (s_to_stream < s_from_stream);
  assign stream_same = (s_to_stream == s_from_stream);
  assign eff_bs      = s_ovr ? s_gsel : s_bs;
  assign d_ext       = {{(CALC_W-DELTA_W){slot_delta[DELTA_W-1]}},
                        slot_delta};

  // special cases follow the effective select, global or local
  assign exc_long  = (!eff_bs && slot_delta == DELTA_P1) ||
                     (eff_bs && slot_delta == DELTA_M127);
  assign exc_short = (!eff_bs && slot_delta == DELTA_P2) ||
                     (eff_bs && slot_delta == DELTA_M126);
  assign is_exc    = exc_long || exc_short;

  // select one: one frame base in both directions; select zero:
  // no base forward, two frames reverse (zero delta counts as reverse)
  assign lat_base = eff_bs ? CALC_W'(LAT_ONE_FRAME) :
                    forward ? '0 :
                    CALC_W'(LAT_TWO_FRAMES);
  assign lat_lin  = lat_base + d_ext;

  assign next_latency = exc_long ? LAT_PIPE_LONG :
                        exc_short ? (stream_neg ? LAT_PIPE_LONGER :
                                     LAT_PIPE_SHORT) :
                        lat_lin[LAT_W-1:0];
  assign dst_abs = CALC_W'(src_full) + CALC_W'(next_latency);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid         <= 1'b0;
      res_latency       <= '0;
      res_frame_offset  <= '0;
      res_buffer_select <= 1'b0;
      res_min_delay     <= 1'b0;
      res_exception     <= 1'b0;
      res_self_loop     <= 1'b0;
    end else begin
      res_valid         <= s_valid;
      res_latency       <= next_latency;
      res_frame_offset  <= dst_abs[FRAME_SHIFT+1:FRAME_SHIFT];
      res_buffer_select <= eff_bs;
      res_min_delay     <= eff_bs ^ forward;
      res_exception     <= is_exc;
      // flagged only: the controller must not ask for this
      res_self_loop     <= (slot_delta == '0) && stream_same;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_VALID_TWO: assert property (req_valid |-> ##2 res_valid)
    else $error("result did not follow request by two cycles");
  AST_FWD_ONE: assert property (
    (s_valid && eff_bs && forward && !is_exc)
      |=> res_latency == 9'(LAT_ONE_FRAME + 9'($past(slot_delta))))
    else $error("forward select-one latency wrong");
  AST_REV_ZERO: assert property (
    (s_valid && !eff_bs && !forward)
      |=> res_latency == 9'(LAT_TWO_FRAMES + 9'($past(d_ext))))
    else $error("reverse select-zero latency wrong");
  AST_FWD_ZERO: assert property (
    (s_valid && !eff_bs && forward && !is_exc)
      |=> res_latency == 9'($past(slot_delta)) && res_min_delay)
    else $error("forward minimum latency wrong");
  AST_REV_ONE: assert property (
    (s_valid && eff_bs && !forward && !is_exc)
      |=> res_latency == 9'(LAT_ONE_FRAME + 9'($past(d_ext))) && res_min_delay)
    else $error("reverse minimum latency wrong");
  AST_EXC_LONG: assert property (
    (s_valid && exc_long) |=> res_latency == LAT_PIPE_LONG && res_exception)
    else $error("pipeline exception latency not 257");
  AST_EXC_SHORT: assert property (
    (s_valid && exc_short) |=> (res_latency ==
      ($past(stream_neg) ? LAT_PIPE_LONGER : LAT_PIPE_SHORT)))
    else $error("pipeline exception latency wrong for stream delta");
  AST_OVR_SEL: assert property (
    (s_valid && s_ovr) |=> res_buffer_select == $past(s_gsel))
    else $error("override did not replace buffer select");
  AST_OVR_LIN: assert property (
    (s_valid && s_ovr && s_gsel && !is_exc) |=> res_latency ==
      9'(LAT_ONE_FRAME + 9'($past(d_ext))))
    else $error("extended linear latency wrong");
  AST_CONST_RANGE: assert property (
    (res_valid && !res_min_delay && !res_exception)
      |-> res_latency >= LAT_ONE_FRAME && res_latency <= LAT_TWO_FRAMES)
    else $error("constant delay outside one to two frames");

  // override checks on the decode, then region and flag checks on registered results only,
  // so those do not lean on the internal decode that they are meant to catch
  AST_OVR_FWD: assert property (
    (s_valid && s_ovr && !s_gsel && forward && !is_exc)
      |=> res_latency == 9'($past(slot_delta)))
    else $error("override select-zero forward latency wrong");
  AST_OVR_REV: assert property (
    (s_valid && s_ovr && !s_gsel && !forward)
      |=> res_latency == 9'(LAT_TWO_FRAMES + 9'($past(d_ext))))
    else $error("override select-zero reverse latency wrong");
  AST_MIN_RANGE: assert property (
    (res_valid && res_min_delay && !res_exception)
      |-> res_latency > LAT_PIPE_SHORT && res_latency <= LAT_ONE_FRAME)
    else $error("minimum delay outside three to one frame");
  AST_MIN_FLAG: assert property (
    (res_valid && !res_exception)
      |-> res_min_delay == (res_latency <= LAT_ONE_FRAME))
    else $error("minimum delay flag disagrees with latency");
  AST_FRAME_OFS: assert property (
    (res_valid && !res_min_delay && !res_exception)
      |-> res_frame_offset == 2'h1 || res_frame_offset == 2'h2)
    else $error("constant delay not one or two frames ahead");
  AST_EXC_VALUES: assert property (
    (res_valid && res_exception) |-> res_latency == LAT_PIPE_LONG ||
      res_latency == LAT_PIPE_LONGER || res_latency == LAT_PIPE_SHORT)
    else $error("exception flagged with an ordinary latency");
  AST_BS_LOCAL: assert property (
    (s_valid && !s_ovr) |=> res_buffer_select == $past(s_bs))
    else $error("per-connection buffer select not used");
  AST_VALID_ONLY: assert property (
    res_valid |-> $past(req_valid, 2))
    else $error("result without a request two cycles before");

  COV_CONST: cover property (res_valid && !res_min_delay);
  COV_MIN:   cover property (res_valid && res_min_delay && !res_exception);
  COV_EXC:   cover property (res_valid && res_exception);
  COV_OVR:   cover property (s_valid && s_ovr && s_gsel);
  COV_SELF:  cover property (res_self_loop);
endmodule

// [test/tsilc_ctrl_model.sv]
// controller model that programs connections into the latency block
`timescale 1ns/100ps
module tsilc_ctrl_model
  import tsilc_pkg::*;
(
  input  wire logic                    want,
  input  wire logic [SLOT_W-1:0]       from_slot,
  input  wire logic [SLOT_W-1:0]       to_slot,
  input  wire logic [STREAM_W_DEF-1:0] from_stream,
  input  wire logic [STREAM_W_DEF-1:0] to_stream,
  output logic                         req_valid
);
  // a slot and stream switched onto itself is held back, never issued
  wire logic self_sw = (from_slot == to_slot) && (from_stream == to_stream);
  assign req_valid = want && !self_sw;
endmodule

// [test/tsilc_connection_latency_control_tb_top.sv]
// self-checking bench for the connection latency block
`timescale 1ns/100ps
module tsilc_connection_latency_control_tb_top;
  import tsilc_pkg::*;
  logic              mclk   = 1'b0;
  logic              arst_n = 1'b0;
  logic              want   = 1'b0;
  logic              req_valid;
  logic [SLOT_W-1:0] fsl    = 7'h00;
  logic [SLOT_W-1:0] tsl    = 7'h00;
  logic [4:0]        fst    = 5'h00;
  logic [4:0]        tst    = 5'h00;
  tsilc_rate_e       fr     = TSILC_RATE_8M;
  tsilc_rate_e       tr     = TSILC_RATE_8M;
  tsilc_rate_e       m_fr   = TSILC_RATE_8M;
  tsilc_rate_e       m_tr   = TSILC_RATE_8M;
  logic              bs     = 1'b0;
  logic              ov     = 1'b0;
  logic              gs     = 1'b0;
  logic              m_bs   = 1'b0;
  logic              m_ov   = 1'b0;
  logic              m_gs   = 1'b0;
  logic              res_valid;
  logic [LAT_W-1:0]  res_latency;
  logic              res_bs;
  logic [1:0]        res_fo;
  logic              res_min;
  logic              res_exc;
  logic              res_self;
  int                error_cnt   = 0;
  int                check_count = 0;

  tsilc_ctrl_model u_ctrl (.want(want), .from_slot(fsl), .to_slot(tsl),
    .from_stream(fst), .to_stream(tst), .req_valid(req_valid));
  tsilc_latency u_dut (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .from_slot(fsl), .to_slot(tsl), .from_rate(fr), .to_rate(tr),
    .from_stream(fst), .to_stream(tst), .buffer_select_bit(bs),
    .override_en(ov), .global_select(gs), .res_valid(res_valid),
    .res_latency(res_latency), .res_frame_offset(res_fo),
    .res_buffer_select(res_bs), .res_min_delay(res_min),
    .res_exception(res_exc), .res_self_loop(res_self));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task end_sim;
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task mode(input logic b, input logic o, input logic g);
    m_bs = b;
    m_ov = o;
    m_gs = g;
  endtask

  // one request; its answer is launched by the first edge after the take,
  // so it is seen right after that edge and sampled high at the second
  task xfer(input logic [6:0] f, input logic [6:0] t, input logic [4:0] s_f,
            input logic [4:0] s_t, input logic [8:0] lat);
    int         i;
    logic [6:0] sf;
    logic [9:0] dst;
    logic       exc;
    logic       mind;
    logic [4:0] want_flags;
    sf   = (m_fr == TSILC_RATE_4M) ? {f[5:0], 1'b0} :
           (m_fr == TSILC_RATE_2M) ? {f[4:0], 2'b00} : f;
    dst  = {3'h0, sf} + {1'h0, lat};
    exc  = (lat == LAT_PIPE_LONG) || (lat == LAT_PIPE_LONGER) ||
           (lat == LAT_PIPE_SHORT);
    mind = exc || (lat <= LAT_ONE_FRAME);
    want_flags = {1'b0, exc, mind, dst[8:7]};
    @(posedge mclk);
    want <= 1'b1;
    fsl  <= f;
    tsl  <= t;
    fst  <= s_f;
    tst  <= s_t;
    fr   <= m_fr;
    tr   <= m_tr;
    bs   <= m_bs;
    ov   <= m_ov;
    gs   <= m_gs;
    @(posedge mclk);
    want <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1;
      if (res_valid === 1'b1) break;
    end
    if (i == 4) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim;
    end else begin
      chk(10'(i), 10'h000);
      chk({res_bs, res_latency}, {(m_ov ? m_gs : m_bs), lat});
      chk(10'({res_self, res_exc, res_min, res_fo}), 10'(want_flags));
      @(posedge mclk);
      #1;
      chk(10'(res_valid), 10'h000);
    end
  endtask

  // a self switch is held back by the controller; the block only flags it
  task t_self;
    int i;
    @(posedge mclk);
    want <= 1'b1;
    fsl  <= 7'h11;
    tsl  <= 7'h11;
    fst  <= 5'h02;
    tst  <= 5'h02;
    fr   <= TSILC_RATE_8M;
    tr   <= TSILC_RATE_8M;
    @(posedge mclk);
    want <= 1'b0;
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      #1;
      chk(10'(res_valid), 10'h000);
    end
    chk(10'(res_self), 10'h001);
    $display("test self switch done");
  endtask

  // reset lands while a request is in flight; its answer must be lost
  task t_reset;
    int i;
    mode(1'b1, 1'b0, 1'b0);
    @(posedge mclk);
    want <= 1'b1;
    fsl  <= 7'h00;
    tsl  <= 7'h7F;
    fst  <= 5'h00;
    tst  <= 5'h01;
    bs   <= 1'b1;
    ov   <= 1'b0;
    @(posedge mclk);
    want   <= 1'b0;
    arst_n <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk({res_valid, res_latency}, 10'h000);
    chk(10'({res_self, res_exc, res_min, res_fo, res_bs}), 10'h000);
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      #1;
      chk(10'(res_valid), 10'h000);
    end
    xfer(7'h00, 7'h7F, 5'h00, 5'h01, 9'h0FF);
    $display("test reset in flight done");
  endtask

  task t_const;
    mode(1'b1, 1'b0, 1'b0);
    xfer(7'h05, 7'h05, 5'h00, 5'h01, 9'h080);
    xfer(7'h00, 7'h7F, 5'h00, 5'h01, 9'h0FF);
    mode(1'b0, 1'b0, 1'b0);
    xfer(7'h7F, 7'h00, 5'h00, 5'h01, 9'h081);
    xfer(7'h25, 7'h01, 5'h00, 5'h01, 9'h0DC);
    $display("test constant delay done");
  endtask

  task t_min;
    mode(1'b0, 1'b0, 1'b0);
    xfer(7'h00, 7'h03, 5'h00, 5'h01, 9'h003);
    xfer(7'h00, 7'h7F, 5'h00, 5'h01, 9'h07F);
    mode(1'b1, 1'b0, 1'b0);
    xfer(7'h7F, 7'h02, 5'h00, 5'h01, 9'h003);
    xfer(7'h25, 7'h01, 5'h00, 5'h01, 9'h05C);
    $display("test minimum delay done");
  endtask

  // stream delta negative versus non-negative at the +2 and -126 corners, one sign each at +1 and -127
  task t_exc;
    mode(1'b0, 1'b0, 1'b0);
    xfer(7'h00, 7'h01, 5'h03, 5'h01, 9'h101);
    xfer(7'h00, 7'h02, 5'h03, 5'h01, 9'h102);
    xfer(7'h00, 7'h02, 5'h01, 5'h03, 9'h002);
    mode(1'b1, 1'b0, 1'b0);
    xfer(7'h7F, 7'h00, 5'h01, 5'h03, 9'h101);
    xfer(7'h7F, 7'h01, 5'h03, 5'h01, 9'h102);
    xfer(7'h7F, 7'h01, 5'h01, 5'h01, 9'h002);
    $display("test pipeline corners done");
  endtask

  // per-connection select set opposite to the global value
  task t_ovr;
    mode(1'b1, 1'b1, 1'b0);
    xfer(7'h00, 7'h03, 5'h00, 5'h01, 9'h003);
    xfer(7'h25, 7'h01, 5'h00, 5'h01, 9'h0DC);
    xfer(7'h00, 7'h01, 5'h00, 5'h01, 9'h101);
    mode(1'b0, 1'b1, 1'b1);
    xfer(7'h7F, 7'h02, 5'h00, 5'h01, 9'h003);
    xfer(7'h00, 7'h7F, 5'h00, 5'h01, 9'h0FF);
    xfer(7'h7F, 7'h00, 5'h00, 5'h01, 9'h101);
    $display("test override done");
  endtask

  task t_rate;
    mode(1'b1, 1'b0, 1'b0);
    m_fr = TSILC_RATE_4M;
    xfer(7'h3F, 7'h7F, 5'h00, 5'h01, 9'h081);
    mode(1'b0, 1'b0, 1'b0);
    m_fr = TSILC_RATE_2M;
    xfer(7'h01, 7'h14, 5'h00, 5'h01, 9'h010);
    m_fr = TSILC_RATE_8M;
    m_tr = TSILC_RATE_2M;
    xfer(7'h00, 7'h1F, 5'h00, 5'h01, 9'h07C);
    m_tr = TSILC_RATE_8M;
    $display("test stream rates done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_const;
    t_min;
    t_exc;
    t_ovr;
    t_self;
    t_reset;
    t_rate;
    end_sim;
  end
endmodule
